// ---- common/ssp_pkg.sv ----
// Constants, types and helpers shared by the serial servant block.
package ssp_pkg;
  // Register byte offsets on the AHB-Lite slave.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFS_CMD = 8'h10;
  localparam logic [7:0] OFS_CMD_INFO = 8'h14;
  localparam logic [7:0] OFS_RESP_DATA = 8'h18;
  localparam logic [7:0] OFS_RESP_CTL = 8'h1c;
  localparam logic [7:0] OFS_GEN_ERR = 8'h20;
  localparam logic [7:0] OFS_ERR_CODE = 8'h24;
  localparam logic [7:0] OFS_XFER = 8'h28;
  // Control and transfer register bit positions.
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SOFT_BIT = 1;
  localparam int XFER_RD_SET = 0;
  localparam int XFER_WR_SET = 1;
  localparam int XFER_RD_CLR = 2;
  localparam int XFER_WR_CLR = 3;
  localparam int XFER_ABORT = 4;
  // Interrupt status bit positions.
  localparam int IRQ_W = 5;
  localparam int IRQ_CMD = 0;
  localparam int IRQ_RD_ABORT = 1;
  localparam int IRQ_WR_ABORT = 2;
  localparam int IRQ_ERR = 3;
  localparam int IRQ_RESP = 4;
  // Protocol error codes, 16-bit two's complement.
  localparam logic [15:0] ERR_CLEAR = 16'hffff;
  localparam logic [15:0] ERR_MULTI_QUERY = 16'hfffd;
  localparam logic [15:0] ERR_UNSUP = 16'hfffc;
  localparam logic [15:0] ERR_DIR_VIOL = 16'hfffb;
  localparam logic [15:0] ERR_DOR_VIOL = 16'hfffa;
  localparam logic [15:0] ERR_RR_VIOL = 16'hfff9;
  localparam logic [15:0] ERR_WR_VIOL = 16'hfff8;
  // Word serial opcodes in the upper command byte; the values are arbitrary.
  localparam logic [7:0] OP_BAV = 8'h10;
  localparam logic [7:0] OP_BREQ = 8'h11;
  localparam logic [7:0] OP_CLEAR = 8'h12;
  localparam logic [7:0] OP_END_NORMAL = 8'h13;
  localparam logic [7:0] OP_ABORT = 8'h14;
  localparam logic [7:0] OP_READ_ERR = 8'h15;
  // AHB-Lite encodings.
  localparam int AHB_ACTIVE_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;
  typedef enum logic [1:0] {CLS_WORD = 2'b00, CLS_LONG = 2'b01, CLS_EXT = 2'b10} ssp_class_t;
  typedef enum logic [1:0] {ACT_NONE = 2'b00, ACT_NORESP = 2'b01, ACT_WORD = 2'b10,
                            ACT_LONG = 2'b11} ssp_act_t;
  typedef enum logic [1:0] {S_IDLE = 2'b00, S_DECODE = 2'b01, S_SOFT = 2'b10} ssp_state_t;
  // Register address match.
  function automatic logic ssp_hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction
endpackage

// ---- common/ssp_ifs.sv ----
// Interfaces between the servant core, its bus slave and its error unit.
`timescale 1ns/1ns
interface ssp_reg_if;
  logic wr_en;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport bus(output wr_en, addr, wdata, input rdata);
  modport regs(input wr_en, addr, wdata, output rdata);
endinterface

interface ssp_err_if;
  logic gen_req;
  logic [15:0] gen_code;
  logic take_req;
  logic [15:0] saved_code;
  logic err_flag;
  logic pending;
  modport user(output gen_req, gen_code, take_req, input saved_code, err_flag, pending);
  modport unit(input gen_req, gen_code, take_req, output saved_code, err_flag, pending);
endinterface

// ---- rtl/ssp_ahb_slave.sv ----
// AHB-Lite slave: zero-wait writes, reads with one wait state.
`timescale 1ns/1ns
module ssp_ahb_slave (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // AHB-Lite.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Register side.
  ssp_reg_if.bus rbus
);
  import ssp_pkg::*;
  logic [7:0] addr_q;
  logic wr_ph_q;
  logic rd_ph_q;
  logic [31:0] hrdata_q;
  // Address phase acceptance.
  wire take = hsel && htrans[AHB_ACTIVE_BIT] && hready;
  // Phase tracking; read data is registered during the wait state.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      addr_q <= 8'h00;
      wr_ph_q <= 1'b0;
      rd_ph_q <= 1'b0;
      hrdata_q <= 32'h0000_0000;
    end else begin
      wr_ph_q <= take && hwrite;
      rd_ph_q <= take && !hwrite;
      if (take) addr_q <= haddr[7:0];
      if (rd_ph_q) hrdata_q <= rbus.rdata;
    end
  end
  // Bus answers and register strobes.
  assign hreadyout = !rd_ph_q;
  assign hrdata = hrdata_q;
  assign hresp = HRESP_OKAY;
  assign rbus.wr_en = wr_ph_q;
  assign rbus.addr = addr_q;
  assign rbus.wdata = hwdata;
endmodule

// ---- rtl/ssp_err_unit.sv ----
// Protocol error store: saved code and error flag.
`timescale 1ns/1ns
module ssp_err_unit (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Error requests and state.
  ssp_err_if.unit eu
);
  import ssp_pkg::*;
  logic [15:0] saved_q;
  logic [15:0] saved_d;
  logic flag_q;
  logic flag_d;
  // Request decode; a read-back empties the slot before a same-cycle error.
  wire gen_set = eu.gen_req && (eu.gen_code != ERR_CLEAR);
  wire gen_clr = eu.gen_req && (eu.gen_code == ERR_CLEAR);
  wire pend = saved_q != ERR_CLEAR;
  wire base_pend = pend && !eu.take_req;
  assign saved_d = (gen_set && !base_pend) ? eu.gen_code :
                   (eu.take_req ? ERR_CLEAR : saved_q);
  assign flag_d = gen_set ? 1'b1 : ((gen_clr || eu.take_req) ? 1'b0 : flag_q);
  // State registers.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      saved_q <= ERR_CLEAR;
      flag_q <= 1'b0;
    end else begin
      saved_q <= saved_d;
      flag_q <= flag_d;
    end
  end
  assign eu.saved_code = saved_q;
  assign eu.err_flag = flag_q;
  assign eu.pending = pend;
  // Checks on the store.
  a_err_first_kept: assert property (
    @(posedge core_clk) disable iff (rst)
    gen_set && pend && !eu.take_req |=> saved_q == $past(saved_q) && flag_q)
    else $error("Pending protocol error was overwritten.");
  a_err_code_saved: assert property (
    @(posedge core_clk) disable iff (rst)
    gen_set && !pend |=> saved_q == $past(eu.gen_code) && flag_q)
    else $error("New protocol error was not saved.");
  a_err_clear_flag: assert property (
    @(posedge core_clk) disable iff (rst)
    gen_clr |=> !flag_q)
    else $error("Clear code left the error flag set.");
endmodule

// ---- rtl/ssp_servant.sv ----
// Servant core: longword and extended serial commands, queries and protocol errors.
// Overview of operation
// - Longword commands dispatched when the soft bit is set, otherwise rejected as unsupported.
// - Query with unread response raises multiple-query.
// - Longword answer fills high, low; sets RR, WR.
// - Command without reply only sets write-ready.
// - Extended longword commands rejected as unsupported unless the soft bit is set.
// - Abort ends pending transfers with forced-abort status.
// - Error saves code and raises error flag.
// - Read-error query returns code, clears, sets RR.
// - No pending error returns the no-error code.
// - Only the first pending error is kept.
// - Clear code drops flag, others raise it.
// - Fixed negative codes for each protocol error.
// - Word answer fills low register; RR, WR.
// - Unexpected byte commands raise ready violations.
`timescale 1ns/1ns
module ssp_servant (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Commander writes and reads.
  input wire logic cmd_strobe,
  input wire ssp_pkg::ssp_class_t cmd_class,
  input wire logic [15:0] cmd_word,
  input wire logic [15:0] cmd_high,
  input wire logic resp_read,
  // Commander-visible data and response bits.
  output logic [15:0] data_high,
  output logic [15:0] data_low,
  output logic read_ready,
  output logic write_ready,
  output logic err_flag,
  output logic rd_pending,
  output logic wr_pending,
  // Interrupt.
  output logic irq
);
  import ssp_pkg::*;

  ssp_reg_if rbus();
  ssp_err_if eu();

  ssp_state_t state_q;
  ssp_state_t state_d;
  ssp_class_t cmd_class_q;
  logic [15:0] cmd_word_q;
  logic [15:0] cmd_high_q;
  logic [15:0] data_high_q;
  logic [15:0] data_low_q;
  logic rr_q;
  logic rr_d;
  logic wr_q;
  logic wr_d;
  logic rd_pend_q;
  logic rd_pend_d;
  logic wr_pend_q;
  logic wr_pend_d;
  logic ctrl_en_q;
  logic ctrl_soft_q;
  logic [31:0] resp_data_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_stat_d;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] evt;
  logic [IRQ_W-1:0] w1c;

  // Bus slave and error store.
  ssp_ahb_slave u_bus (
    .core_clk(core_clk),
    .rst(rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .rbus(rbus.bus)
  );

  ssp_err_unit u_err (
    .core_clk(core_clk),
    .rst(rst),
    .eu(eu.unit)
  );

  // Register write strobes.
  wire w_ctrl = rbus.wr_en && ssp_hit(rbus.addr, OFS_CTRL);
  wire w_irq_stat = rbus.wr_en && ssp_hit(rbus.addr, OFS_IRQ_STAT);
  wire w_irq_mask = rbus.wr_en && ssp_hit(rbus.addr, OFS_IRQ_MASK);
  wire w_resp_data = rbus.wr_en && ssp_hit(rbus.addr, OFS_RESP_DATA);
  wire w_resp_ctl = rbus.wr_en && ssp_hit(rbus.addr, OFS_RESP_CTL);
  wire w_gen_err = rbus.wr_en && ssp_hit(rbus.addr, OFS_GEN_ERR);
  wire w_xfer = rbus.wr_en && ssp_hit(rbus.addr, OFS_XFER);

  // Commander handshake: writes need write-ready, reads need read-ready.
  wire cmd_take = cmd_strobe && wr_q;
  wire viol_wr = cmd_strobe && !wr_q;
  wire viol_rr = resp_read && !rr_q;

  // Decode of the captured command.
  wire [7:0] opcode = cmd_word_q[15:8];
  wire is_word = cmd_class_q == CLS_WORD;
  wire is_bav = is_word && (opcode == OP_BAV);
  wire is_breq = is_word && (opcode == OP_BREQ);
  wire is_rpe = is_word && (opcode == OP_READ_ERR);
  wire is_abort_cmd = is_word && ((opcode == OP_CLEAR) || (opcode == OP_END_NORMAL)
                      || (opcode == OP_ABORT));
  wire is_plain_word = is_word && !is_bav && !is_breq && !is_rpe && !is_abort_cmd;
  wire in_decode = (state_q == S_DECODE) && ctrl_en_q;

  // Decode outcomes; exactly one is true in an enabled decode cycle.
  wire dec_soft = in_decode && ((!is_word && ctrl_soft_q) || (is_bav && rd_pend_q)
                  || (is_breq && wr_pend_q) || is_plain_word);
  wire dec_unsup = in_decode && !is_word && !ctrl_soft_q;
  wire dec_dir = in_decode && is_bav && !rd_pend_q;
  wire dec_dor = in_decode && is_breq && !wr_pend_q;
  wire dec_abort = in_decode && is_abort_cmd;
  wire dec_rpe = in_decode && is_rpe;
  wire rpe_mq = dec_rpe && rr_q;
  wire rpe_ok = dec_rpe && !rr_q;

  // Software answers while a command waits for it.
  wire [1:0] act = rbus.wdata[1:0];
  wire sw_ans = w_resp_ctl && (state_q == S_SOFT) && (act != ACT_NONE);
  wire sw_noresp = sw_ans && (act == ACT_NORESP);
  wire sw_word = sw_ans && (act == ACT_WORD);
  wire sw_long = sw_ans && (act == ACT_LONG);
  wire sw_query = sw_word || sw_long;
  wire sw_mq = sw_query && rr_q;
  wire sw_post = sw_query && !rr_q;

  // Abort from the commander or from software.
  wire abort_req = dec_abort || (w_xfer && rbus.wdata[XFER_ABORT]);

  // Ready bits: set wins over a same-cycle clear.
  wire wr_set = dec_unsup || dec_dir || dec_dor || dec_abort || dec_rpe || sw_ans;
  wire rr_set = rpe_ok || sw_post;
  assign rr_d = rr_set || (rr_q && !resp_read);
  assign wr_d = wr_set || (wr_q && !cmd_take);

  // Pending transfers; an abort overrides a same-cycle start.
  wire rd_set = w_xfer && rbus.wdata[XFER_RD_SET];
  wire rd_clr = w_xfer && rbus.wdata[XFER_RD_CLR];
  wire wrp_set = w_xfer && rbus.wdata[XFER_WR_SET];
  wire wrp_clr = w_xfer && rbus.wdata[XFER_WR_CLR];
  assign rd_pend_d = !abort_req && (rd_set || (rd_pend_q && !rd_clr));
  assign wr_pend_d = !abort_req && (wrp_set || (wr_pend_q && !wrp_clr));

  // Error requests in priority order; software requests come last.
  assign eu.gen_req = viol_wr || viol_rr || rpe_mq || sw_mq || dec_unsup
                      || dec_dir || dec_dor || w_gen_err;
  assign eu.gen_code = viol_wr ? ERR_WR_VIOL :
                       viol_rr ? ERR_RR_VIOL :
                       (rpe_mq || sw_mq) ? ERR_MULTI_QUERY :
                       dec_unsup ? ERR_UNSUP :
                       dec_dir ? ERR_DIR_VIOL :
                       dec_dor ? ERR_DOR_VIOL : rbus.wdata[15:0];
  assign eu.take_req = rpe_ok;

  // Interrupt events, sticky status cleared by writing ones.
  assign evt[IRQ_CMD] = dec_soft;
  assign evt[IRQ_RD_ABORT] = abort_req && rd_pend_q;
  assign evt[IRQ_WR_ABORT] = abort_req && wr_pend_q;
  assign evt[IRQ_ERR] = eu.gen_req && (eu.gen_code != ERR_CLEAR);
  assign evt[IRQ_RESP] = resp_read && rr_q;
  assign w1c = w_irq_stat ? rbus.wdata[IRQ_W-1:0] : '0;
  assign irq_stat_d = evt | (irq_stat_q & ~w1c);

  // Command sequencer.
  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (cmd_take) state_d = S_DECODE;
      end
      S_DECODE: begin
        if (dec_soft) state_d = S_SOFT;
        else if (ctrl_en_q) state_d = S_IDLE;
      end
      S_SOFT: begin
        if (sw_ans) state_d = S_IDLE;
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  // Sequencer and handshake registers.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= S_IDLE;
      rr_q <= 1'b0;
      wr_q <= 1'b1;
      rd_pend_q <= 1'b0;
      wr_pend_q <= 1'b0;
      irq_stat_q <= '0;
    end else begin
      state_q <= state_d;
      rr_q <= rr_d;
      wr_q <= wr_d;
      rd_pend_q <= rd_pend_d;
      wr_pend_q <= wr_pend_d;
      irq_stat_q <= irq_stat_d;
    end
  end

  // Captured command.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmd_class_q <= CLS_WORD;
      cmd_word_q <= 16'h0000;
      cmd_high_q <= 16'h0000;
    end else if (cmd_take) begin
      cmd_class_q <= cmd_class;
      cmd_word_q <= cmd_word;
      cmd_high_q <= cmd_high;
    end
  end

  // Response data registers seen by the commander.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      data_high_q <= 16'h0000;
      data_low_q <= 16'h0000;
    end else begin
      if (rpe_ok) data_low_q <= eu.saved_code;
      if (sw_post) data_low_q <= resp_data_q[15:0];
      if (sw_post && sw_long) data_high_q <= resp_data_q[31:16];
    end
  end

  // Software-written configuration.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_en_q <= 1'b0;
      ctrl_soft_q <= 1'b0;
      irq_mask_q <= '0;
      resp_data_q <= 32'h0000_0000;
    end else begin
      if (w_ctrl) ctrl_en_q <= rbus.wdata[CTRL_EN_BIT];
      if (w_ctrl) ctrl_soft_q <= rbus.wdata[CTRL_SOFT_BIT];
      if (w_irq_mask) irq_mask_q <= rbus.wdata[IRQ_W-1:0];
      if (w_resp_data) resp_data_q <= rbus.wdata;
    end
  end

  // Read-back words.
  wire [31:0] ctrl_word = {30'h0000_0000, ctrl_soft_q, ctrl_en_q};
  wire [31:0] status_word = {25'h000_0000, state_q, wr_pend_q, rd_pend_q, eu.err_flag,
                             wr_q, rr_q};
  wire [31:0] info_word = {30'h0000_0000, cmd_class_q};
  wire [31:0] err_word = {15'h0000, eu.pending, eu.saved_code};
  wire [31:0] stat_word = {27'h000_0000, irq_stat_q};
  wire [31:0] mask_word = {27'h000_0000, irq_mask_q};
  assign rbus.rdata = ssp_hit(rbus.addr, OFS_CTRL) ? ctrl_word :
                      ssp_hit(rbus.addr, OFS_STATUS) ? status_word :
                      ssp_hit(rbus.addr, OFS_IRQ_STAT) ? stat_word :
                      ssp_hit(rbus.addr, OFS_IRQ_MASK) ? mask_word :
                      ssp_hit(rbus.addr, OFS_CMD) ? {cmd_high_q, cmd_word_q} :
                      ssp_hit(rbus.addr, OFS_CMD_INFO) ? info_word :
                      ssp_hit(rbus.addr, OFS_RESP_DATA) ? resp_data_q :
                      ssp_hit(rbus.addr, OFS_ERR_CODE) ? err_word : 32'h0000_0000;

  // Outputs.
  assign data_high = data_high_q;
  assign data_low = data_low_q;
  assign read_ready = rr_q;
  assign write_ready = wr_q;
  assign err_flag = eu.err_flag;
  assign rd_pending = rd_pend_q;
  assign wr_pending = wr_pend_q;
  assign irq = |(irq_stat_q & irq_mask_q);

  // Checks on the servant behaviour.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  a_long_unsup: assert property (
    dec_unsup && (cmd_class_q == CLS_LONG) && !cmd_strobe && !resp_read
    |-> eu.gen_req && eu.gen_code == ERR_UNSUP ##1 wr_q && state_q == S_IDLE)
    else $error("Longword command was not rejected as unsupported.");

  a_ext_unsup: assert property (
    in_decode && (cmd_class_q == CLS_EXT) && !ctrl_soft_q && !cmd_strobe && !resp_read
    |=> wr_q && irq_stat_q[IRQ_ERR])
    else $error("Extended command was not rejected.");

  a_query_multi: assert property (
    sw_query && rr_q && !cmd_strobe |-> eu.gen_code == ERR_MULTI_QUERY
    ##1 $stable(data_low_q) && $stable(data_high_q))
    else $error("Second response replaced an unread one.");

  a_long_post: assert property (
    sw_long && !rr_q |=> rr_q && wr_q && data_high_q == $past(resp_data_q[31:16])
    && data_low_q == $past(resp_data_q[15:0]))
    else $error("Longword response was not posted.");

  a_noresp_wr: assert property (
    sw_noresp && !resp_read |=> wr_q && rr_q == $past(rr_q) && $stable(data_low_q))
    else $error("Reply-less command changed more than write-ready.");

  a_abort_ends: assert property (
    abort_req && rd_pend_q |=> !rd_pend_q && !wr_pend_q && irq_stat_q[IRQ_RD_ABORT])
    else $error("Abort did not end the pending read.");

  a_rpe_post: assert property (
    rpe_ok && !eu.gen_req |=> rr_q && wr_q && !eu.err_flag
    && data_low_q == $past(eu.saved_code) && eu.saved_code == ERR_CLEAR)
    else $error("Read-error query was not answered.");

  a_rpe_none: assert property (
    rpe_ok && !eu.pending |=> data_low_q == ERR_CLEAR)
    else $error("No-error query did not return the no-error code.");

  a_word_post: assert property (
    sw_word && !rr_q |=> rr_q && wr_q && $stable(data_high_q)
    && data_low_q == $past(resp_data_q[15:0]))
    else $error("Word response was not posted to the low register.");

  a_byte_viol: assert property (
    dec_dor && !cmd_strobe && !resp_read |-> eu.gen_req && eu.gen_code == ERR_DOR_VIOL)
    else $error("Byte request without a pending write was accepted.");
endmodule

// ---- bench/ssp_commander.sv ----
// Commander model: writes serial commands and reads responses.
`timescale 1ns/1ns
module ssp_commander (
  // Clock.
  input wire logic core_clk,
  // Command and response strobes.
  output logic cmd_strobe,
  output ssp_pkg::ssp_class_t cmd_class,
  output logic [15:0] cmd_word,
  output logic [15:0] cmd_high,
  output logic resp_read
);
  import ssp_pkg::*;
  // Idle levels at time zero.
  initial begin
    cmd_strobe = 1'b0;
    cmd_class = CLS_WORD;
    cmd_word = 16'h0000;
    cmd_high = 16'h0000;
    resp_read = 1'b0;
  end
  // One command pulse; afterwards the data lines are no longer valid, so they flip.
  task automatic send(input ssp_class_t c, input logic [15:0] hi, input logic [15:0] lo);
    @(posedge core_clk);
    cmd_strobe <= 1'b1;
    cmd_class <= c;
    cmd_high <= hi;
    cmd_word <= lo;
    @(posedge core_clk);
    cmd_strobe <= 1'b0;
    cmd_high <= ~hi;
    cmd_word <= ~lo;
  endtask
  // One response read pulse.
  task automatic take_resp();
    @(posedge core_clk);
    resp_read <= 1'b1;
    @(posedge core_clk);
    resp_read <= 1'b0;
  endtask
endmodule

// ---- bench/serial_servant_protocol_errors_tb_top.sv ----
// Testbench for the serial servant: bus master, commander model and scenarios.
`timescale 1ns/1ns
module serial_servant_protocol_errors_tb_top;
  import ssp_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout, hresp, cmd_strobe, resp_read, read_ready, write_ready, err_flag;
  logic rd_pending, wr_pending, irq;
  logic [31:0] hrdata, rd;
  logic [15:0] cmd_word, cmd_high, data_high, data_low;
  ssp_class_t cmd_class;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;

  // Design and commander model; the one slave drives hready.
  ssp_servant u_dut (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cmd_strobe(cmd_strobe),
    .cmd_class(cmd_class), .cmd_word(cmd_word), .cmd_high(cmd_high), .resp_read(resp_read),
    .data_high(data_high), .data_low(data_low), .read_ready(read_ready),
    .write_ready(write_ready), .err_flag(err_flag), .rd_pending(rd_pending),
    .wr_pending(wr_pending), .irq(irq));
  ssp_commander u_cmdr (.core_clk(core_clk), .cmd_strobe(cmd_strobe), .cmd_class(cmd_class),
    .cmd_word(cmd_word), .cmd_high(cmd_high), .resp_read(resp_read));

  // Clock and hang limit.
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  // Verdict and end of run.
  task automatic print_verdict();
    if (n_mismatch == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Compare one value.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Single word transfer: address phase, then data phase, each held until hready.
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
    @(negedge core_clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string m);
    ahb(1'b0, a, 32'hdead_beef);
    chk(rd, exp, m);
  endtask
  // Bounded wait for write-ready, then let the edge settle.
  task automatic wait_wr();
    int i;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (write_ready !== 1'b1 && i < 50);
    chk(write_ready, 1'b1, "write ready");
    @(negedge core_clk);
  endtask
  task automatic cmd(input ssp_class_t c, input logic [15:0] hi, input logic [15:0] lo);
    u_cmdr.send(c, hi, lo);
    wait_wr();
  endtask
  // Software response through the data and control registers.
  task automatic resp(input logic [31:0] d, input logic [1:0] c);
    wr(OFS_RESP_DATA, d);
    wr(OFS_RESP_CTL, {30'h0000_0000, c});
    wait_wr();
  endtask
  // Read protocol error query and the response read that follows it.
  task automatic query_err(input logic [15:0] exp);
    cmd(CLS_WORD, 16'h0000, {OP_READ_ERR, 8'h00});
    chk(data_low, exp, "saved code");
    chk({read_ready, err_flag}, 2'b10, "rr and flag");
    rdc(OFS_ERR_CODE, 32'h0000_ffff, "code reset");
    u_cmdr.take_resp();
    @(negedge core_clk);
    chk(read_ready, 1'b0, "rr after read");
  endtask

  // Reset values at the pins and in the registers, and an unmapped read.
  task automatic t_reset();
    chk({hreadyout, hresp, read_ready, write_ready, err_flag, rd_pending, wr_pending, irq},
        8'h90, "reset pins");
    chk({data_high, data_low}, 32'h0000_0000, "reset data");
    rdc(OFS_STATUS, 32'h0000_0002, "reset status");
    rdc(OFS_ERR_CODE, 32'h0000_ffff, "reset code");
    rdc(OFS_IRQ_MASK, 32'h0000_0000, "reset mask");
    rdc(8'h40, 32'h0000_0000, "unmapped");
  endtask
  // Hardware rejection of longword and extended commands, first error kept, clear code.
  task automatic t_reject();
    wr(OFS_CTRL, 32'h0000_0001);
    wr(OFS_IRQ_MASK, 32'h0000_0008);
    query_err(ERR_CLEAR);
    cmd(CLS_LONG, 16'h1234, 16'h5678);
    chk({err_flag, irq}, 2'b11, "long reject");
    rdc(OFS_ERR_CODE, 32'h0001_fffc, "unsup code");
    wr(OFS_GEN_ERR, 32'h0000_fffa);
    rdc(OFS_ERR_CODE, 32'h0001_fffc, "first kept");
    wr(OFS_IRQ_STAT, 32'h0000_001f);
    chk(irq, 1'b0, "irq cleared");
    query_err(ERR_UNSUP);
    cmd(CLS_EXT, 16'h00a5, 16'h5a00);
    rdc(OFS_ERR_CODE, 32'h0001_fffc, "ext reject");
    wr(OFS_GEN_ERR, 32'h0000_ffff);
    chk(err_flag, 1'b0, "clear code");
    query_err(ERR_UNSUP);
  endtask
  // Software responses: longword, multiple query, no reply, word.
  task automatic t_soft();
    wr(OFS_CTRL, 32'h0000_0003);
    u_cmdr.send(CLS_LONG, 16'h0001, 16'h0002);
    rdc(OFS_STATUS, 32'h0000_0040, "soft wait");
    rdc(OFS_CMD, 32'h0001_0002, "cmd held");
    resp(32'ha5a5_3c3c, 2'b11);
    chk({data_high, data_low}, 32'ha5a5_3c3c, "long resp");
    chk(read_ready, 1'b1, "long rr");
    u_cmdr.send(CLS_LONG, 16'h0003, 16'h0004);
    resp(32'h1111_2222, 2'b11);
    chk({data_high, data_low}, 32'ha5a5_3c3c, "mqe data");
    chk(err_flag, 1'b1, "mqe flag");
    rdc(OFS_ERR_CODE, 32'h0001_fffd, "mqe code");
    u_cmdr.send(CLS_LONG, 16'h0005, 16'h0006);
    resp(32'h0000_0000, 2'b01);
    chk({read_ready, data_low}, 32'h0001_3c3c, "no reply");
    cmd(CLS_WORD, 16'h0000, {OP_READ_ERR, 8'h00});
    chk({read_ready, data_low}, 32'h0001_3c3c, "query unread");
    u_cmdr.take_resp();
    u_cmdr.send(CLS_WORD, 16'h0000, 16'h2000);
    resp(32'h7777_8888, 2'b10);
    chk({data_high, data_low}, 32'ha5a5_8888, "word resp");
    chk(read_ready, 1'b1, "word rr");
    u_cmdr.take_resp();
    wr(OFS_CTRL, 32'h0000_0001);
    query_err(ERR_MULTI_QUERY);
  endtask
  // Abort by each commander command and locally.
  task automatic t_abort();
    logic [7:0] ops[3] = '{OP_CLEAR, OP_END_NORMAL, OP_ABORT};
    wr(OFS_IRQ_MASK, 32'h0000_0006);
    for (int k = 0; k < 4; k++) begin
      wr(OFS_IRQ_STAT, 32'h0000_001f);
      wr(OFS_XFER, 32'h0000_0003);
      chk({rd_pending, wr_pending, irq}, 3'b110, "pending");
      if (k < 3) begin
        cmd(CLS_WORD, 16'h0000, {ops[k], 8'h00});
      end else begin
        wr(OFS_XFER, 32'h0000_0010);
      end
      chk({rd_pending, wr_pending, irq}, 3'b001, "abort");
      rdc(OFS_IRQ_STAT, 32'h0000_0006, "forced abort");
    end
  endtask
  // Ready violations and a software error.
  task automatic t_viol();
    cmd(CLS_WORD, 16'h0000, {OP_BAV, 8'h00});
    query_err(ERR_DIR_VIOL);
    cmd(CLS_WORD, 16'h0000, {OP_BREQ, 8'h00});
    query_err(ERR_DOR_VIOL);
    u_cmdr.take_resp();
    @(negedge core_clk);
    query_err(ERR_RR_VIOL);
    wr(OFS_CTRL, 32'h0000_0000);
    u_cmdr.send(CLS_WORD, 16'h0000, {OP_CLEAR, 8'h00});
    u_cmdr.send(CLS_WORD, 16'h0000, {OP_CLEAR, 8'h00});
    wr(OFS_CTRL, 32'h0000_0001);
    wait_wr();
    query_err(ERR_WR_VIOL);
    wr(OFS_GEN_ERR, 32'h0000_fff9);
    chk(err_flag, 1'b1, "gen error");
    query_err(ERR_RR_VIOL);
  endtask

  // Main sequence.
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    t_reset();
    t_reject();
    t_soft();
    t_abort();
    t_viol();
    print_verdict();
  end
endmodule
